// *** rtl/memctl_pkg.sv ***
/*
 pin-level memory controller package: constants, enums and carrier structs.
 assumes the single design file imports it whole.
*/
package memctl_pkg;
   localparam int NUM_SEL = 8;
   localparam int NUM_LANE = 8;
   localparam int NUM_GPL = 6;
   localparam int ADDR_W = 32;
   localparam int PROG_DEPTH = 16;
   localparam int PROG_IDX_W = 4;
   // size code: 0 byte, 1 half, 2 word, 3 double
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_DBL = 2'h3;
   // port width code: 0 8-bit, 1 16-bit, 2 32-bit, 3 64-bit
   localparam logic [1:0] PORT_8 = 2'h0;
   localparam int BURST_LO = 3;
   localparam int BURST_HI = 4;
   localparam int A10_ROW_BIT = 10;
   localparam logic [1:0] BCTL_DIR = 2'h0;
   localparam logic [1:0] BCTL_ENA = 2'h1;
   localparam logic [1:0] BCTL_SPLIT = 2'h2;
   localparam logic [7:0] LANES_OFF = 8'h00;

   typedef enum logic [1:0] {
      MACH_SIMPLE = 2'h0,
      MACH_PROG = 2'h1,
      MACH_SDRAM = 2'h2
   } machine_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_CMD = 3'h3,
      ST_DATA = 3'h2,
      ST_DONE = 3'h6
   } state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] size;
      logic [1:0] port_w;
      logic write;
      logic [2:0] bank;
      machine_t mach;
   } access_t;

   // one word of the waveform program
   typedef struct packed {
      logic [5:0] gpl;
      logic bs_on;
      logic wait_chk;
      logic last;
   } prog_word_t;
endpackage

// *** rtl/memctl_pins.sv ***
/*
 memory controller pin logic: chip-select, programmable waveform and sdram
 machines sharing one pin set. assumes a request source on the same clock,
 a program table loaded over the prog_wr ports, and external ack/wait pins.
*/
// Notes on behaviour
// (R1) eight chip selects, one per device
// (R2) two buffer controls, function set by config
// (R3) drive burst address bits 27 to 28
// (R4) address latch enable in external-master mode
// (R5) eight byte write strobes from simple machine
// (R6) eight sdram byte masks
// (R7) program-timed byte selects from address, size, width
// (R8) a10: row address bit, command on column
// (R9) separate sdram write, row, column strobes
// (R10) six program-driven general lines
// (R11) read output enable during simple machine reads
// (R12) external ack ends simple machine access
// (R13) wait input high stalls waveform program
// (R14) parity chip byte select output
// (R15) sdram address mux control in external-master
// (R16) one machine drives strobes per access
module memctl_pins
   import memctl_pkg::*;
#(
   parameter int SEL_N = NUM_SEL
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire access_t req_i,
   output logic done_o,
   input wire logic ext_master_i,
   input wire logic [1:0] buffer_ctrl_function_sel_i,
   input wire logic prog_wr_i,
   input wire logic [PROG_IDX_W-1:0] prog_idx_i,
   input wire prog_word_t prog_data_i,
   input wire logic simple_machine_ack_n_i,
   input wire logic prog_machine_wait_i,
   output logic [SEL_N-1:0] chip_sel_n_o,
   output logic data_buffer_ctrl_a_o,
   output logic data_buffer_ctrl_b_o,
   output logic [1:0] burst_addr_out_o,
   output logic addr_latch_en_o,
   output logic [NUM_LANE-1:0] byte_write_strobe_n_o,
   output logic [NUM_LANE-1:0] sdram_byte_mask_o,
   output logic [NUM_LANE-1:0] prog_byte_select_n_o,
   output logic sdram_addr_bit_ten_o,
   output logic sdram_write_strobe_n_o,
   output logic sdram_row_strobe_n_o,
   output logic sdram_column_strobe_n_o,
   output logic [NUM_GPL-1:0] prog_general_line_o,
   output logic read_output_enable_n_o,
   output logic parity_chip_select_n_o,
   output logic sdram_addr_mux_ctrl_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, change accepted when stages two and three agree

   logic [2:0] ack_sync_reg;
   logic [2:0] wait_sync_reg;
   logic ack_seen_reg;
   logic wait_seen_reg;
   logic ack_seen_next;
   logic wait_seen_next;

   assign ack_seen_next = (ack_sync_reg[1] == ack_sync_reg[2]) ? ~ack_sync_reg[2] : ack_seen_reg;
   assign wait_seen_next = (wait_sync_reg[1] == wait_sync_reg[2]) ? wait_sync_reg[2]
                                                                  : wait_seen_reg;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_sync_reg <= 3'h7;
         wait_sync_reg <= 3'h0;
         ack_seen_reg <= 1'b0;
         wait_seen_reg <= 1'b0;
      end else begin
         ack_sync_reg <= {ack_sync_reg[1:0], simple_machine_ack_n_i};
         wait_sync_reg <= {wait_sync_reg[1:0], prog_machine_wait_i};
         ack_seen_reg <= ack_seen_next;
         wait_seen_reg <= wait_seen_next;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// waveform program store

   prog_word_t prog_mem_reg [PROG_DEPTH];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < PROG_DEPTH; i++) begin
            prog_mem_reg[i] <= '{gpl: 6'h3F, bs_on: 1'b0, wait_chk: 1'b0, last: 1'b1};
         end
      end else if (prog_wr_i) begin
         prog_mem_reg[prog_idx_i] <= prog_data_i;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// access sequencer

   state_t state_reg;
   state_t state_next;
   access_t acc_reg;
   logic [PROG_IDX_W-1:0] pc_reg;
   logic [PROG_IDX_W-1:0] pc_next;
   prog_word_t cur_word;
   logic stall_wait;
   logic simple_end;
   logic prog_end;
   logic ack_armed_reg;
   logic ack_armed_next;

   // an ack still held from the last access must be released before it may end the next one
   assign ack_armed_next = !ack_seen_reg ? 1'b1
                                         : ((state_reg == ST_DONE) ? 1'b0 : ack_armed_reg);
   assign cur_word = prog_mem_reg[pc_reg];
   assign stall_wait = cur_word.wait_chk && wait_seen_reg; // [R13]
   assign simple_end = (acc_reg.mach == MACH_SIMPLE) && ack_seen_reg && ack_armed_reg; // [R12]
   assign prog_end = (acc_reg.mach == MACH_PROG) && !stall_wait && cur_word.last;
   assign req_ready_o = (state_reg == ST_IDLE);
   assign pc_next = (state_reg == ST_DATA && acc_reg.mach == MACH_PROG && !stall_wait)
                    ? pc_reg + 1'b1 : (state_reg == ST_IDLE ? '0 : pc_reg);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (req_valid_i) begin
               state_next = ST_ADDR;
            end
         end
         ST_ADDR: begin
            state_next = (acc_reg.mach == MACH_SDRAM) ? ST_CMD : ST_DATA;
         end
         ST_CMD: begin
            state_next = ST_DATA;
         end
         ST_DATA: begin
            if (simple_end || prog_end || acc_reg.mach == MACH_SDRAM) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
         acc_reg <= '0;
         pc_reg <= '0;
         ack_armed_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         ack_armed_reg <= ack_armed_next;
         pc_reg <= pc_next;
         if (state_reg == ST_IDLE && req_valid_i) begin
            acc_reg <= req_i;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// lane decode from address, size and port width

   logic [2:0] offs;
   logic [3:0] n_bytes;
   logic [3:0] port_bytes;
   logic [7:0] lanes;
   logic [NUM_LANE-1:0] lanes_all;

   assign port_bytes = 4'h1 << acc_reg.port_w;
   assign n_bytes = 4'h1 << acc_reg.size;
   // narrow ports see lanes from the bottom; bytes past lane 7 drop
   assign offs = acc_reg.addr[2:0] & 3'(port_bytes - 4'h1);
   assign lanes_all = 8'(((16'h1 << n_bytes) - 16'h1) << offs);
   assign lanes = (acc_reg.port_w == PORT_8) ? 8'h01 : lanes_all; // [R7]

////////////////////////////////////////////////////////////////////////////////
// pin drive: machine strobes qualified by the machine owning the access; chip selects by any active access

   logic active;
   logic use_simple;
   logic use_prog;
   logic use_sdram;
   logic [SEL_N-1:0] cs_next;
   logic [NUM_LANE-1:0] we_next;
   logic [NUM_LANE-1:0] dqm_next;
   logic [NUM_LANE-1:0] bs_next;
   logic ras_next;
   logic cas_next;
   logic swe_next;
   logic a10_next;
   logic oe_next;
   logic [NUM_GPL-1:0] gpl_next;

   assign active = (state_reg == ST_ADDR || state_reg == ST_CMD || state_reg == ST_DATA);
   assign use_simple = active && acc_reg.mach == MACH_SIMPLE; // [R16]
   assign use_prog = active && acc_reg.mach == MACH_PROG; // [R16]
   assign use_sdram = active && acc_reg.mach == MACH_SDRAM; // [R16]
   assign cs_next = active ? ~(SEL_N'(1) << acc_reg.bank) : '1; // [R1]
   assign we_next = (use_simple && acc_reg.write && state_reg == ST_DATA) ? ~lanes : '1; // [R5]
   assign oe_next = ~(use_simple && !acc_reg.write && state_reg == ST_DATA); // [R11]
   assign bs_next = (use_prog && cur_word.bs_on) ? ~lanes : '1; // [R7]
   assign gpl_next = use_prog ? cur_word.gpl : '1; // [R10]
   assign dqm_next = use_sdram ? ~lanes : '1; // [R6]
   // row phase opens the bank, column phase issues read or write
   assign ras_next = ~(use_sdram && state_reg == ST_ADDR); // [R9]
   assign cas_next = ~(use_sdram && state_reg == ST_CMD); // [R9]
   assign swe_next = ~(use_sdram && state_reg == ST_CMD && acc_reg.write); // [R9]
   // column phase: a10 high requests auto-precharge
   assign a10_next = (use_sdram && state_reg == ST_ADDR) ? acc_reg.addr[A10_ROW_BIT]
                                                         : use_sdram; // [R8]

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chip_sel_n_o <= '1;
         byte_write_strobe_n_o <= '1;
         read_output_enable_n_o <= 1'b1;
         prog_byte_select_n_o <= '1;
         prog_general_line_o <= '1;
         sdram_byte_mask_o <= '1;
         sdram_row_strobe_n_o <= 1'b1;
         sdram_column_strobe_n_o <= 1'b1;
         sdram_write_strobe_n_o <= 1'b1;
         sdram_addr_bit_ten_o <= 1'b0;
         parity_chip_select_n_o <= 1'b1;
         burst_addr_out_o <= '0;
         addr_latch_en_o <= 1'b0;
         sdram_addr_mux_ctrl_o <= 1'b0;
         data_buffer_ctrl_a_o <= 1'b1;
         data_buffer_ctrl_b_o <= 1'b1;
         done_o <= 1'b0;
      end else begin
         chip_sel_n_o <= cs_next; // [R1]
         byte_write_strobe_n_o <= we_next; // [R5]
         read_output_enable_n_o <= oe_next; // [R11]
         prog_byte_select_n_o <= bs_next; // [R7]
         prog_general_line_o <= gpl_next; // [R10]
         sdram_byte_mask_o <= dqm_next; // [R6]
         sdram_row_strobe_n_o <= ras_next; // [R9]
         sdram_column_strobe_n_o <= cas_next; // [R9]
         sdram_write_strobe_n_o <= swe_next; // [R9]
         sdram_addr_bit_ten_o <= a10_next; // [R8]
         parity_chip_select_n_o <= ~(use_prog && cur_word.bs_on); // [R14]
         burst_addr_out_o <= active ? acc_reg.addr[BURST_HI:BURST_LO] : 2'h0; // [R3]
         addr_latch_en_o <= ext_master_i && state_reg == ST_ADDR; // [R4]
         sdram_addr_mux_ctrl_o <= ext_master_i && use_sdram && state_reg != ST_ADDR; // [R15]
         case (buffer_ctrl_function_sel_i) // [R2]
            BCTL_DIR: begin
               data_buffer_ctrl_a_o <= ~(active && acc_reg.write);
               data_buffer_ctrl_b_o <= ~active;
            end
            BCTL_ENA: begin
               data_buffer_ctrl_a_o <= ~active;
               data_buffer_ctrl_b_o <= ~active;
            end
            BCTL_SPLIT: begin
               data_buffer_ctrl_a_o <= ~(active && acc_reg.write);
               data_buffer_ctrl_b_o <= ~(active && !acc_reg.write);
            end
            default: begin
               data_buffer_ctrl_a_o <= 1'b1;
               data_buffer_ctrl_b_o <= 1'b1;
            end
         endcase
         done_o <= (state_next == ST_DONE);
      end
   end

endmodule

// *** test/memctl_pins_properties.sv ***
/*
 port checker for memctl_pins.
 assumes one clock domain and the bind at the foot of this file.
*/
module memctl_pins_properties
   import memctl_pkg::*;
#(
   parameter int SEL_N = NUM_SEL
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire access_t req_i,
   input wire logic done_o,
   input wire logic ext_master_i,
   input wire logic simple_machine_ack_n_i,
   input wire logic addr_latch_en_o,
   input wire logic [NUM_LANE-1:0] byte_write_strobe_n_o,
   input wire logic sdram_addr_bit_ten_o,
   input wire logic sdram_row_strobe_n_o,
   input wire logic sdram_column_strobe_n_o,
   input wire logic read_output_enable_n_o,
   input wire logic sdram_addr_mux_ctrl_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic take;
   logic ack_seen;
   access_t held;
   assign take = req_valid_i && req_ready_o;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         held <= '0;
         ack_seen <= 1'b0;
      end else if (take) begin
         held <= req_i;
         ack_seen <= 1'b0;
      end else if (!simple_machine_ack_n_i) begin
         ack_seen <= 1'b1;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_sdram_latency: assert property (take && req_i.mach == MACH_SDRAM |-> ##[4:5] done_o)
      else $error("sdram access finished late");
   a_ack_ends: assert property (done_o && held.mach == MACH_SIMPLE |-> ack_seen)
      else $error("simple access ended without ack");
   a_a10_column: assert property (!sdram_column_strobe_n_o |-> sdram_addr_bit_ten_o)
      else $error("a10 low in column phase");
   a_a10_row: assert property (!sdram_row_strobe_n_o && sdram_column_strobe_n_o
      |-> sdram_addr_bit_ten_o == held.addr[A10_ROW_BIT]) else $error("a10 not row bit");
   a_oe_reads: assert property (!read_output_enable_n_o |-> !held.write)
      else $error("output enable on a write");
   a_we_writes: assert property (byte_write_strobe_n_o != 8'hFF |-> held.write)
      else $error("byte write strobe on a read");
   a_mux_ext: assert property (sdram_addr_mux_ctrl_o |-> ext_master_i)
      else $error("mux control outside external-master mode");
   a_ale_ext: assert property (addr_latch_en_o |-> ext_master_i)
      else $error("latch enable outside external-master mode");
   a_one_machine: assert property (!sdram_row_strobe_n_o |-> read_output_enable_n_o
      && byte_write_strobe_n_o == 8'hFF) else $error("two machines drive strobes");
   a_busy_refuses: assert property (take |=> !req_ready_o [*2])
      else $error("ready while an access runs");
   c_sdram: cover property (take && req_i.mach == MACH_SDRAM);
   c_simple: cover property (done_o && held.mach == MACH_SIMPLE);
   c_prog: cover property (done_o && held.mach == MACH_PROG);
endmodule

bind memctl_pins memctl_pins_properties #(.SEL_N(SEL_N)) u_props (.clk_i, .rst_n_i,
   .req_valid_i, .req_ready_o, .req_i, .done_o, .ext_master_i, .simple_machine_ack_n_i,
   .addr_latch_en_o, .byte_write_strobe_n_o, .sdram_addr_bit_ten_o, .sdram_row_strobe_n_o,
   .sdram_column_strobe_n_o, .read_output_enable_n_o, .sdram_addr_mux_ctrl_o);

// *** test/mem_far_side.sv ***
/*
 far-side memory: acks a selected access and stretches program waits.
 assumes the controller clock.
*/
module mem_far_side (
   input wire logic clk_i,
   input wire logic sel_n_i,
   input wire logic prog_act_i,
   input wire logic [3:0] ack_dly_i,
   input wire logic [3:0] stall_i,
   output logic ack_n_o,
   output logic wait_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] sel_cnt = 4'h0;
   logic [3:0] act_cnt = 4'h0;
   always_ff @(posedge clk_i) begin
      if (sel_n_i)
         sel_cnt <= 4'h0;
      else if (sel_cnt != 4'hF)
         sel_cnt <= sel_cnt + 4'h1;
      if (!prog_act_i)
         act_cnt <= 4'h0;
      else if (act_cnt != 4'hF)
         act_cnt <= act_cnt + 4'h1;
   end
   // unselected, the pull-up holds the ack line high
   assign ack_n_o = sel_n_i || (sel_cnt < ack_dly_i);
   // a slow device holds wait for stall_i cycles once a program runs
   assign wait_o = prog_act_i && (act_cnt < stall_i);
endmodule

// *** test/external_memory_controller_pins_tb.sv ***
/*
 self-checking bench for memctl_pins.
 assumes the far-side model and the bound checker are compiled first.
*/
module external_memory_controller_pins_tb
   import memctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic req_valid_i = 1'b0;
   logic ext_master_i = 1'b0;
   logic prog_wr_i = 1'b0;
   logic [1:0] buffer_ctrl_function_sel_i = 2'h0;
   logic [3:0] prog_idx_i = 4'h0;
   prog_word_t prog_data_i = '0;
   access_t req_i = '0;
   logic [3:0] stall = 4'h0;
   logic req_ready_o, done_o, simple_machine_ack_n_i, prog_machine_wait_i;
   logic data_buffer_ctrl_a_o, data_buffer_ctrl_b_o, addr_latch_en_o, sdram_addr_bit_ten_o;
   logic sdram_write_strobe_n_o, sdram_row_strobe_n_o, sdram_column_strobe_n_o;
   logic read_output_enable_n_o, parity_chip_select_n_o, sdram_addr_mux_ctrl_o;
   logic [7:0] chip_sel_n_o, byte_write_strobe_n_o, sdram_byte_mask_o, prog_byte_select_n_o;
   logic [1:0] burst_addr_out_o;
   logic [5:0] prog_general_line_o;
   logic [7:0] cs_acc, we_acc, msk_acc, bs_acc;
   logic [9:0] fl;
   logic [1:0] ba_acc;
   int err_count = 0;
   int n_compared = 0;
   int c0, c1;
   always #12.5 clk_i = ~clk_i;
   memctl_pins u_dut (.clk_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_i, .done_o,
      .ext_master_i, .buffer_ctrl_function_sel_i, .prog_wr_i, .prog_idx_i, .prog_data_i,
      .simple_machine_ack_n_i, .prog_machine_wait_i, .chip_sel_n_o, .data_buffer_ctrl_a_o,
      .data_buffer_ctrl_b_o, .burst_addr_out_o, .addr_latch_en_o, .byte_write_strobe_n_o,
      .sdram_byte_mask_o, .prog_byte_select_n_o, .sdram_addr_bit_ten_o, .sdram_write_strobe_n_o,
      .sdram_row_strobe_n_o, .sdram_column_strobe_n_o, .prog_general_line_o,
      .read_output_enable_n_o, .parity_chip_select_n_o, .sdram_addr_mux_ctrl_o);
   mem_far_side u_far (.clk_i, .sel_n_i(&chip_sel_n_o),
      .prog_act_i(prog_general_line_o != 6'h3F), .ack_dly_i(4'h2), .stall_i(stall),
      .ack_n_o(simple_machine_ack_n_i), .wait_o(prog_machine_wait_i));
   //////////////////////////////////////////////////////////////////////////////
   task check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // flags: oe ras cas sdwe mux ale bufa bufb parity gpl_2A, each ever active
   task sample;
      cs_acc |= ~chip_sel_n_o;
      we_acc |= ~byte_write_strobe_n_o;
      msk_acc |= ~sdram_byte_mask_o;
      bs_acc |= ~prog_byte_select_n_o;
      ba_acc |= burst_addr_out_o;
      fl |= {~read_output_enable_n_o, ~sdram_row_strobe_n_o, ~sdram_column_strobe_n_o,
         ~sdram_write_strobe_n_o, sdram_addr_mux_ctrl_o, addr_latch_en_o, ~data_buffer_ctrl_a_o,
         ~data_buffer_ctrl_b_o, ~parity_chip_select_n_o, prog_general_line_o == 6'h2A};
   endtask
   // poke keeps a second request up while busy; it must be ignored
   task automatic run(input access_t a, input bit poke, output int cyc);
      int n;
      {cs_acc, we_acc, msk_acc, bs_acc, fl, ba_acc} = '0;
      req_i = a;
      req_valid_i = 1'b1;
      @(posedge clk_i);
      #1;
      req_valid_i = poke;
      req_i.bank = 3'h7;
      for (n = 0; n < 80 && done_o !== 1'b1; n++) begin
         @(posedge clk_i);
         #1;
         sample();
      end
      req_valid_i = 1'b0;
      cyc = n;
      if (n == 80) begin
         check("done", 10'h0, 10'h1);
         wrap_up();
      end
      repeat (3) begin
         @(posedge clk_i);
         #1;
         sample();
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task sc_sdram;
      run('{32'h418, SIZE_WORD, 2'h3, 1'b1, 3'h1, MACH_SDRAM}, 1'b1, c0);
      check("cs", 10'(cs_acc), 10'h002);
      check("dqm", 10'(msk_acc), 10'h00F);
      check("flags", fl & 10'h3FD, 10'h1CC);
      check("burst_addr_out", 10'(ba_acc), 10'h003);
   endtask
   task sc_ext;
      ext_master_i = 1'b1;
      run('{32'h0, SIZE_DBL, 2'h3, 1'b0, 3'h2, MACH_SDRAM}, 1'b0, c0);
      ext_master_i = 1'b0;
      check("dqm", 10'(msk_acc), 10'h0FF);
      check("flags", fl & 10'h07C, 10'h034);
      check("burst_addr_out", 10'(ba_acc), 10'h000);
   endtask
   task sc_simple;
      buffer_ctrl_function_sel_i = BCTL_ENA;
      run('{32'h0, SIZE_WORD, 2'h3, 1'b0, 3'h5, MACH_SIMPLE}, 1'b0, c0);
      check("cs", 10'(cs_acc), 10'h020);
      check("flags", fl & 10'h34C, 10'h20C);
      buffer_ctrl_function_sel_i = 2'h3;
      run('{32'h2, SIZE_HALF, 2'h3, 1'b1, 3'h0, MACH_SIMPLE}, 1'b0, c0);
      check("we", 10'(we_acc), 10'h00C);
      check("flags", fl & 10'h20C, 10'h000);
      buffer_ctrl_function_sel_i = BCTL_SPLIT;
      run('{32'h5, SIZE_BYTE, PORT_8, 1'b1, 3'h0, MACH_SIMPLE}, 1'b0, c0);
      check("we", 10'(we_acc), 10'h001);
      check("flags", fl & 10'h00C, 10'h008);
      buffer_ctrl_function_sel_i = BCTL_DIR;
   endtask
   task sc_prog;
      prog_word_t pw [6];
      // long enough for a wait raised at select to cross the pin synchroniser
      pw = '{'{6'h2A, 1'b1, 1'b1, 1'b0}, '{6'h15, 1'b1, 1'b1, 1'b0}, '{6'h2A, 1'b1, 1'b1, 1'b0},
         '{6'h15, 1'b1, 1'b1, 1'b0}, '{6'h2A, 1'b1, 1'b1, 1'b0}, '{6'h3F, 1'b0, 1'b0, 1'b1}};
      prog_wr_i = 1'b1;
      for (int i = 0; i < 6; i++) begin
         prog_idx_i = 4'(i);
         prog_data_i = pw[i];
         @(posedge clk_i);
         #1;
      end
      prog_wr_i = 1'b0;
      run('{32'h4, SIZE_WORD, 2'h3, 1'b0, 3'h3, MACH_PROG}, 1'b0, c0);
      check("bs", 10'(bs_acc), 10'h0F0);
      check("flags", fl & 10'h103, 10'h003);
      stall = 4'h8;
      run('{32'h4, SIZE_WORD, 2'h3, 1'b0, 3'h3, MACH_PROG}, 1'b0, c1);
      stall = 4'h0;
      check("stall", 10'(c1 >= c0 + 5), 10'h001);
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      sc_sdram();
      sc_ext();
      sc_simple();
      sc_prog();
      wrap_up();
   end
endmodule
